// *** ssr_defines.svh ***
// Constants for the system status read-back block
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH

// ----------------------------------------------------------------
// Register port offsets
// ----------------------------------------------------------------
`define SSR_OFF_ACCESS   4'h0
`define SSR_OFF_IRQ_ST   4'h4
`define SSR_OFF_IRQ_MASK 4'h8
`define SSR_OFF_MODE     4'hc
`define SSR_OFF_RSS      4'ha

// ----------------------------------------------------------------
// Access word fields
// ----------------------------------------------------------------
`define SSR_ADDR_HI      15
`define SSR_ADDR_LO      14
`define SSR_RRS_BIT      13
`define SSR_RO_BIT       12
`define SSR_MODE_HI      11
`define SSR_MODE_LO      0
`define SSR_ADDR_STATUS  2'b00
`define SSR_RRS_STATUS   1'b0
`define SSR_RO_READONLY  1'b1

// ----------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------
`define SSR_RSS_HI       11
`define SSR_RSS_LO       8
`define SSR_RSV7_BIT     7
`define SSR_LWS_BIT      6
`define SSR_RSV5_BIT     5
`define SSR_RSV_VALUE    1'b0

// ----------------------------------------------------------------
// Reset source codes
// ----------------------------------------------------------------
`define SSR_RSS_POWER_ON   4'h0
`define SSR_RSS_CYCLIC     4'h1
`define SSR_RSS_MAIN_LOW   4'h2
`define SSR_RSS_MAIN_OVC   4'h3
`define SSR_RSS_SW_SHORT   4'h4
`define SSR_RSS_RESERVED   4'h5
`define SSR_RSS_FLASH      4'h6
`define SSR_RSS_WAKE_CAN   4'h7
`define SSR_RSS_WAKE_LIN   4'h8
`define SSR_RSS_WAKE_PIN   4'h9
`define SSR_RSS_FAILSAFE   4'ha
`define SSR_RSS_WD_LATE    4'hb
`define SSR_RSS_WD_INIT    4'hc
`define SSR_RSS_WD_EARLY   4'hd
`define SSR_RSS_ILL_MODE   4'he
`define SSR_RSS_IRQ_LATE   4'hf

// ----------------------------------------------------------------
// Interrupt status bits and reset values
// ----------------------------------------------------------------
`define SSR_IRQ_RESET    0
`define SSR_IRQ_WAKE     1
`define SSR_IRQ_MODE     2
`define SSR_IRQ_NONE     3'h0
`define SSR_WORD_ZERO    16'h0000
`define SSR_MODE_ZERO    12'h000

`endif

// *** ssr_pkg.sv ***
// Types shared by the system status read-back block
package ssr_pkg;

    typedef logic [15:0] ssr_word_t;
    typedef logic [3:0]  ssr_code_t;

    typedef struct packed {
        ssr_word_t   snap;
        logic [11:0] mode;
        logic        mode_wr;
        ssr_code_t   rss;
        logic [2:0]  irq_st;
        logic [2:0]  irq_mask;
        ssr_word_t   rdata;
        logic        wake_q;
    } ssr_state_s;

endpackage

// *** ssr_cause_enc.sv ***
// Priority encoder from reset cause events to a reset source code
`timescale 1ns/100ps
`include "ssr_defines.svh"
module ssr_cause_enc
    import ssr_pkg::*;
(
    input  wire logic [15:0] cause_evt,
    output logic             evt_any,
    output ssr_code_t        code
);

    logic [15:0] valid;
    ssr_code_t   pick [0:16];

    // Reserved cause can never be recorded
    assign valid = cause_evt & ~(16'h0001 << `SSR_RSS_RESERVED);

    assign pick[16] = `SSR_RSS_POWER_ON;

    // Lowest code wins, so power-on beats every other cause
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_pick
            assign pick[i] = valid[i] ? ssr_code_t'(i) : pick[i+1];
        end
    endgenerate

    assign evt_any = |valid;
    assign code    = pick[0];

endmodule

// *** ssr_status_readback.sv ***
// System status read-back: access word decode, reset source, wake level
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`include "ssr_defines.svh"
module ssr_status_readback
    import ssr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_output_pin,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [15:0]      rdata,
    input  wire logic        evt_power_on,
    input  wire logic        evt_cyclic_wake,
    input  wire logic        evt_main_low,
    input  wire logic        evt_main_ovc,
    input  wire logic        evt_switched_short,
    input  wire logic        evt_flash_entry,
    input  wire logic        evt_wake_can,
    input  wire logic        evt_wake_lin,
    input  wire logic        evt_wake_pin,
    input  wire logic        evt_failsafe_wake,
    input  wire logic        evt_wd_late,
    input  wire logic        evt_wd_no_init,
    input  wire logic        evt_wd_early,
    input  wire logic        evt_illegal_mode,
    input  wire logic        evt_irq_unserved,
    input  wire logic        wake_level,
    output logic [11:0]      mode_word,
    output logic             mode_write,
    output logic [3:0]       reset_source,
    output logic             irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    ssr_state_s  cur_reg;
    ssr_state_s  cur_next;

    logic [15:0] cause_evt;
    logic        cause_any;
    ssr_code_t   cause_code;

    logic        acc_hit;
    logic        acc_sel;
    logic        acc_ro;
    logic        wake_chg;
    logic [2:0]  irq_evt;
    ssr_word_t   status_now;

    // ----------------------------------------------------------------
    // Reset cause encoding
    // ----------------------------------------------------------------
    always_comb begin
        cause_evt = 16'h0000;
        cause_evt[`SSR_RSS_POWER_ON] = evt_power_on;
        cause_evt[`SSR_RSS_CYCLIC]   = evt_cyclic_wake;
        cause_evt[`SSR_RSS_MAIN_LOW] = evt_main_low;
        cause_evt[`SSR_RSS_MAIN_OVC] = evt_main_ovc;
        cause_evt[`SSR_RSS_SW_SHORT] = evt_switched_short;
        cause_evt[`SSR_RSS_FLASH]    = evt_flash_entry;
        cause_evt[`SSR_RSS_WAKE_CAN] = evt_wake_can;
        cause_evt[`SSR_RSS_WAKE_LIN] = evt_wake_lin;
        cause_evt[`SSR_RSS_WAKE_PIN] = evt_wake_pin;
        cause_evt[`SSR_RSS_FAILSAFE] = evt_failsafe_wake;
        cause_evt[`SSR_RSS_WD_LATE]  = evt_wd_late;
        cause_evt[`SSR_RSS_WD_INIT]  = evt_wd_no_init;
        cause_evt[`SSR_RSS_WD_EARLY] = evt_wd_early;
        cause_evt[`SSR_RSS_ILL_MODE] = evt_illegal_mode;
        cause_evt[`SSR_RSS_IRQ_LATE] = evt_irq_unserved;
    end

    ssr_cause_enc u_enc (
        .cause_evt (cause_evt),
        .evt_any   (cause_any),
        .code      (cause_code)
    );

    // ----------------------------------------------------------------
    // Access word decode
    // ----------------------------------------------------------------
    assign acc_hit = wr && (addr == `SSR_OFF_ACCESS);

    // Other address or select values belong to other registers
    assign acc_sel = acc_hit
        && (wdata[`SSR_ADDR_HI:`SSR_ADDR_LO] == `SSR_ADDR_STATUS)
        && (wdata[`SSR_RRS_BIT] == `SSR_RRS_STATUS);

    assign acc_ro = (wdata[`SSR_RO_BIT] == `SSR_RO_READONLY);

    // ----------------------------------------------------------------
    // Live status word
    // ----------------------------------------------------------------
    always_comb begin
        status_now = `SSR_WORD_ZERO;
        status_now[`SSR_ADDR_HI:`SSR_ADDR_LO] = `SSR_ADDR_STATUS;
        status_now[`SSR_RRS_BIT] = `SSR_RRS_STATUS;
        status_now[`SSR_RO_BIT]  = wdata[`SSR_RO_BIT];
        status_now[`SSR_RSS_HI:`SSR_RSS_LO] = cur_reg.rss;
        status_now[`SSR_RSV7_BIT] = `SSR_RSV_VALUE;
        status_now[`SSR_LWS_BIT]  = wake_level;
        status_now[`SSR_RSV5_BIT] = `SSR_RSV_VALUE;
    end

    // ----------------------------------------------------------------
    // Interrupt events
    // ----------------------------------------------------------------
    assign wake_chg = wake_level ^ cur_reg.wake_q;

    always_comb begin
        irq_evt = `SSR_IRQ_NONE;
        irq_evt[`SSR_IRQ_RESET] = cause_any;
        irq_evt[`SSR_IRQ_WAKE]  = wake_chg;
        irq_evt[`SSR_IRQ_MODE]  = acc_sel && !acc_ro;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        cur_next = cur_reg;
        cur_next.mode_wr = 1'b0;
        cur_next.rdata   = `SSR_WORD_ZERO;
        cur_next.wake_q  = wake_level;

        // Latest cause always replaces the old one
        if (cause_any) begin
            cur_next.rss = cause_code;
        end

        // Snapshot taken at the access, not at the later read
        if (acc_sel) begin
            cur_next.snap = status_now;
            if (!acc_ro) begin
                cur_next.mode    = wdata[`SSR_MODE_HI:`SSR_MODE_LO];
                cur_next.mode_wr = 1'b1;
            end
        end

        if (wr && (addr == `SSR_OFF_IRQ_MASK)) begin
            cur_next.irq_mask = wdata[2:0];
        end

        // Write one to clear; a new event in the same cycle wins
        if (wr && (addr == `SSR_OFF_IRQ_ST)) begin
            cur_next.irq_st = cur_reg.irq_st & ~wdata[2:0];
        end
        cur_next.irq_st = cur_next.irq_st | irq_evt;

        if (rd) begin
            case (addr)
                `SSR_OFF_ACCESS: begin
                    cur_next.rdata = cur_reg.snap;
                end
                `SSR_OFF_IRQ_ST: begin
                    cur_next.rdata = {13'h0000, cur_reg.irq_st};
                end
                `SSR_OFF_IRQ_MASK: begin
                    cur_next.rdata = {13'h0000, cur_reg.irq_mask};
                end
                `SSR_OFF_MODE: begin
                    cur_next.rdata = {4'h0, cur_reg.mode};
                end
                `SSR_OFF_RSS: begin
                    cur_next.rdata = {12'h000, cur_reg.rss};
                end
                default: begin
                    cur_next.rdata = `SSR_WORD_ZERO;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Power-up leaves the power-on code in place
    always_ff @(posedge clk or negedge reset_output_pin) begin
        if (!reset_output_pin) begin
            cur_reg.snap     <= `SSR_WORD_ZERO;
            cur_reg.mode     <= `SSR_MODE_ZERO;
            cur_reg.mode_wr  <= 1'b0;
            cur_reg.rss      <= `SSR_RSS_POWER_ON;
            cur_reg.irq_st   <= `SSR_IRQ_NONE;
            cur_reg.irq_mask <= `SSR_IRQ_NONE;
            cur_reg.rdata    <= `SSR_WORD_ZERO;
            cur_reg.wake_q   <= 1'b0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rdata        = cur_reg.rdata;
    assign mode_word    = cur_reg.mode;
    assign mode_write   = cur_reg.mode_wr;
    assign reset_source = cur_reg.rss;
    assign irq          = |(cur_reg.irq_st & cur_reg.irq_mask);

endmodule

// *** ssr_status_readback_sva.sv ***
// Assertions for the system status read-back block
`timescale 1ns/100ps
module ssr_status_readback_sva
    import ssr_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset_output_pin,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        evt_power_on,
    input wire logic [11:0] mode_word,
    input wire logic        mode_write,
    input wire logic [3:0]  reset_source
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_output_pin);
    logic acc;
    logic rda;
    assign acc = wr && addr == 4'h0;
    assign rda = rd && addr == 4'h0;
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    AST_SELECT: assert property (acc && wdata[15:13] != 3'h0 |=> !mode_write)
        else $error("mode written by a deselected access");
    AST_MODE_RO: assert property (acc && wdata[15:12] == 4'h1 |=> !mode_write && $stable(mode_word))
        else $error("read-only access changed mode");
    AST_MODE_WR: assert property (acc && wdata[15:12] == 4'h0 |=> mode_write && mode_word == $past(wdata[11:0]))
        else $error("mode not stored by access");
    AST_MODE_HOLD: assert property (!acc |=> !mode_write && $stable(mode_word))
        else $error("mode changed without access");
    AST_POWER_ON: assert property (evt_power_on |=> reset_source == 4'h0)
        else $error("power-on code not recorded");
    AST_NO_RSV: assert property (reset_source != 4'h5)
        else $error("reserved source code produced");
    AST_RSV: assert property ($past(rda) |-> rdata[7] == 1'b0 && rdata[5] == 1'b0)
        else $error("reserved status bit set");
    AST_TOP: assert property ($past(rda) |-> rdata[15:13] == 3'h0)
        else $error("status address field not zero");
    COV_WR: cover property (acc && wdata[15:12] == 4'h0);
    COV_RO: cover property (acc && wdata[15:12] == 4'h1);
    COV_RD: cover property (rda ##1 rdata != 16'h0000);
endmodule

bind ssr_status_readback ssr_status_readback_sva u_sva (.clk(clk), .reset_output_pin(reset_output_pin), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .evt_power_on(evt_power_on),
    .mode_word(mode_word), .mode_write(mode_write), .reset_source(reset_source));

// *** ssr_host_model.sv ***
// Host model driving the register port of the read-back block
`timescale 1ns/100ps
module ssr_host_model (
    input  wire logic        clk,
    input  wire logic [15:0] rdata,
    output logic [3:0]       addr,
    output logic [15:0]      wdata,
    output logic             wr,
    output logic             rd
);
    initial begin
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end
    // Status word selected: address 00, read select 0
    function automatic logic [15:0] acc_word(logic ro, logic [11:0] m);
        return {2'b00, 1'b0, ro, m};
    endfunction
    task automatic put(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic get(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
endmodule

// *** ssr_status_readback_tb.sv ***
// Self-checking testbench for the system status read-back block
`timescale 1ns/100ps
module ssr_status_readback_tb;
    logic        clk, reset_output_pin, wake_level, wr, rd, mode_write, irq;
    logic [14:0] evts;
    logic [3:0]  addr, reset_source;
    logic [15:0] wdata, rdata, got;
    logic [11:0] mode_word;
    int          failures, tests_run;
    ssr_host_model host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
    ssr_status_readback DUT (.clk(clk), .reset_output_pin(reset_output_pin), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .evt_power_on(evts[0]), .evt_cyclic_wake(evts[1]),
        .evt_main_low(evts[2]), .evt_main_ovc(evts[3]), .evt_switched_short(evts[4]),
        .evt_flash_entry(evts[5]), .evt_wake_can(evts[6]), .evt_wake_lin(evts[7]),
        .evt_wake_pin(evts[8]), .evt_failsafe_wake(evts[9]), .evt_wd_late(evts[10]),
        .evt_wd_no_init(evts[11]), .evt_wd_early(evts[12]), .evt_illegal_mode(evts[13]),
        .evt_irq_unserved(evts[14]), .wake_level(wake_level), .mode_word(mode_word),
        .mode_write(mode_write), .reset_source(reset_source), .irq(irq));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] stat(logic ro, logic [3:0] c, logic w);
        return {3'b000, ro, c, 1'b0, w, 6'h00};
    endfunction
    // No event input exists for the reserved code
    function automatic logic [3:0] code_of(int i);
        return (i < 5) ? 4'(i) : 4'(i + 1);
    endfunction
    task automatic check(string n, logic [15:0] s, logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic pulse(int i);
        @(posedge clk);
        evts <= 15'h0001 << i;
        @(posedge clk);
        evts <= 15'h0000;
        @(negedge clk);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        @(negedge clk);
        check("rdata", rdata, 16'h0000);
        check("outputs", {mode_word, reset_source}, 16'h0000);
        check("flags", {14'h0000, mode_write, irq}, 16'h0000);
    endtask
    task automatic t_codes();
        for (int i = 14; i >= 0; i--) begin
            pulse(i);
            check("source", {12'h000, reset_source}, {12'h000, code_of(i)});
            repeat (3) @(posedge clk);
            host.put(4'h0, host.acc_word(1'b1, 12'h000));
            host.get(4'h0, got);
            check("status", got, stat(1'b1, code_of(i), 1'b0));
        end
    endtask
    // Event on the access edge must not leak into that word
    task automatic t_coherent();
        @(posedge clk);
        wake_level <= 1'b1;
        fork
            host.put(4'h0, host.acc_word(1'b1, 12'h000));
            begin
                @(posedge clk);
                evts <= 15'h0400;
                @(posedge clk);
                evts <= 15'h0000;
            end
        join
        host.get(4'h0, got);
        check("status", got, stat(1'b1, 4'h0, 1'b1));
        host.get(4'ha, got);
        check("source", got, 16'h000b);
    endtask
    task automatic t_mode();
        host.put(4'h0, host.acc_word(1'b0, 12'habc));
        @(negedge clk);
        check("mode", {3'h0, mode_write, mode_word}, 16'h1abc);
        host.put(4'h0, host.acc_word(1'b1, 12'h123));
        @(negedge clk);
        check("mode", {3'h0, mode_write, mode_word}, 16'h0abc);
        host.put(4'h0, 16'h6555);
        host.get(4'h0, got);
        check("status", got, stat(1'b1, 4'hb, 1'b1));
        host.get(4'h2, got);
        check("unmapped", got, 16'h0000);
    endtask
    task automatic t_irq();
        host.put(4'h8, 16'h0007);
        @(negedge clk);
        check("irq", {15'h0000, irq}, 16'h0001);
        host.get(4'h4, got);
        check("irq_status", got, 16'h0007);
        host.put(4'h4, 16'h0007);
        @(negedge clk);
        check("irq", {15'h0000, irq}, 16'h0000);
        host.put(4'h8, 16'h0000);
        pulse(3);
        check("irq", {15'h0000, irq}, 16'h0000);
        host.get(4'h4, got);
        check("irq_status", got, 16'h0001);
    endtask
    // ----------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        reset_output_pin = 1'b0;
        evts = 15'h0000;
        wake_level = 1'b0;
        failures = 0;
        tests_run = 0;
        repeat (10) @(posedge clk);
        reset_output_pin <= 1'b1;
        @(posedge clk);
        t_reset();
        t_codes();
        t_coherent();
        t_mode();
        t_irq();
        conclude();
    end
    initial begin
        #100000;
        failures++;
        conclude();
    end
endmodule
